/* File: common/bas_pkg.sv */
// Overview of operation
// - Software selects 32-bit or 16-bit averaging
// - Average length minimum and step per mode
// - Average length maximum by mode and channels
// - Average count between 2 and mode limit
// - Results are signed, 32 or 16 bits
// - Re-arm between waveforms within pretrigger plus 80/160/320
// - Next average ready within 50 us
// - Statistics segment at least 64, step 32
// - Statistics segment maximum 2G over channels; streaming mode allows 2G at any channel count
// - One 32-byte record per statistics segment
// - Record holds average, min, max, positions, timestamp
// - Re-arm between segments within pretrigger plus 80/160/320
// - All reduction done inside the logic
package bas_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the AXI4-Lite slave
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LEN    = 8'h04;
  localparam logic [7:0] REG_COUNT  = 8'h08;
  localparam logic [7:0] REG_CHAN   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_DONE   = 8'h14;

  // CTRL bits
  localparam int CTRL_START  = 0;
  localparam int CTRL_STAT   = 1;
  localparam int CTRL_W16    = 2;
  localparam int CTRL_ABORT  = 3;
  localparam int CTRL_STREAM = 4;
  // STATUS bits
  localparam int STS_BUSY    = 0;
  localparam int STS_CFGERR  = 1;
  localparam int STS_DONE    = 2;

  // Reset values
  localparam logic [31:0] LEN_RST   = 32'h0000_0040;
  localparam logic [31:0] COUNT_RST = 32'h0000_0002;
  localparam logic [2:0]  CHAN_RST  = 3'h1;

  // ----------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------
  localparam int AVG_MIN_LEN32  = 64;
  localparam int AVG_STEP32     = 32;
  localparam int AVG_MIN_LEN16  = 128;
  localparam int AVG_STEP16     = 64;
  localparam int AVG_MAX_LEN32  = 65536;
  localparam int AVG_MAX_LEN16  = 131072;
  localparam int AVG_MIN_COUNT  = 2;
  localparam int AVG_MAX_CNT32  = 16777216;
  localparam int AVG_MAX_CNT16  = 256;
  localparam int STAT_MIN_LEN   = 64;
  localparam int STAT_STEP      = 32;
  localparam logic [32:0] STAT_MAX_LEN = 33'h0_8000_0000;
  localparam int REC_WORDS      = 8;

  // ----------------------------------------------------------------
  // Timing, one sample per clock at 250 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int REARM_SMP_LO   = 80;
  localparam int REARM_SMP_MID  = 160;
  localparam int REARM_SMP_HI   = 320;
  localparam int REARM_CYC      = 1;
  localparam int NEXT_AVG_US    = 50;
  localparam int DIV_STEPS      = 40;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARM  = 3'h1,
    ST_RUN  = 3'h3,
    ST_DUMP = 3'h2,
    ST_DIV  = 3'h6,
    ST_REC  = 3'h7
  } bas_state_t;

endpackage

/* File: common/bas_if.sv */
`timescale 1ns/1ps
interface bas_if;
  logic        trig;
  logic [63:0] ts;
  logic        smp_valid;
  logic [7:0]  smp_data;
  logic        armed;
  logic        wr_valid;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic        wr_ack;

  modport dev (input trig, ts, smp_valid, smp_data, wr_ack,
               output armed, wr_valid, wr_addr, wr_data);
  modport acq (output trig, ts, smp_valid, smp_data, wr_ack,
               input armed, wr_valid, wr_addr, wr_data);
endinterface

/* File: design/bas_stat.sv */
`timescale 1ns/1ps
module bas_stat import bas_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  smp,
  input  wire logic [31:0] pos,
  input  wire logic        finish,
  input  wire logic [31:0] len,
  output logic [7:0]       min_reg,
  output logic [7:0]       max_reg,
  output logic [31:0]      pmin_reg,
  output logic [31:0]      pmax_reg,
  output logic [39:0]      sum_reg,
  output logic [31:0]      avg_reg,
  output logic             done_reg
);
  // ----------------------------------------------------------------
  // Running min, max and sum
  // ----------------------------------------------------------------
  wire logic signed [7:0] s     = smp;
  wire logic              lower = clr || (s < $signed(min_reg));
  wire logic              upper = clr || (s > $signed(max_reg));
  wire logic [39:0]       sext  = {{32{smp[7]}}, smp};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      min_reg  <= 8'h00;
      max_reg  <= 8'h00;
      pmin_reg <= 32'h0000_0000;
      pmax_reg <= 32'h0000_0000;
      sum_reg  <= 40'h00_0000_0000;
    end else if (en) begin
      sum_reg <= clr ? sext : sum_reg + sext;
      if (lower) begin
        min_reg  <= smp;
        pmin_reg <= pos;
      end
      if (upper) begin
        max_reg  <= smp;
        pmax_reg <= pos;
      end
    end
  end

  // ----------------------------------------------------------------
  // Signed average by restoring division, one bit per clock
  // ----------------------------------------------------------------
  logic [32:0] rem_reg;
  logic [39:0] quo_reg;
  logic [5:0]  cnt_reg;
  logic        neg_reg;
  logic        run_reg;
  wire logic [32:0] rem_sh = {rem_reg[31:0], quo_reg[39]};
  wire logic        fits   = rem_sh >= {1'b0, len};
  wire logic [39:0] mag    = sum_reg[39] ? 40'h00_0000_0000 - sum_reg
                                         : sum_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_reg  <= 33'h0_0000_0000;
      quo_reg  <= 40'h00_0000_0000;
      cnt_reg  <= 6'h00;
      neg_reg  <= 1'b0;
      run_reg  <= 1'b0;
      avg_reg  <= 32'h0000_0000;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (finish) begin
        rem_reg <= 33'h0_0000_0000;
        quo_reg <= mag;
        neg_reg <= sum_reg[39];
        cnt_reg <= 6'h00;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        rem_reg <= fits ? rem_sh - {1'b0, len} : rem_sh;
        quo_reg <= {quo_reg[38:0], fits};
        cnt_reg <= cnt_reg + 6'h01;
        if (cnt_reg == 6'(DIV_STEPS - 1)) begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
          avg_reg  <= neg_reg ? 32'h0000_0000 - {quo_reg[30:0], fits}
                              : {quo_reg[30:0], fits};
        end
      end
    end
  end
endmodule // bas_stat

/* File: design/bas_engine.sv */
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bas_engine import bas_pkg::*; #(
  parameter int ACC_DEPTH    = AVG_MAX_LEN16,
  parameter int NEXT_AVG_CYC = NEXT_AVG_US * CLK_MHZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  bas_if.dev               lnk,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int AW = $clog2(ACC_DEPTH);

  if (ACC_DEPTH < AVG_MIN_LEN16 || NEXT_AVG_CYC < ACC_DEPTH) begin : g_chk
    $error("bas_engine: accumulator depth out of range");
  end

  // ----------------------------------------------------------------
  // Configuration check
  // ----------------------------------------------------------------
  function automatic logic cfg_ok(input logic stat, input logic w16,
                                  input logic strm, input logic [2:0] ch,
                                  input logic [31:0] len,
                                  input logic [31:0] cnt);
    logic [1:0]  sh;
    logic [32:0] lmax;
    sh = (ch >= 3'h3) ? 2'h2 : ((ch == 3'h2) ? 2'h1 : 2'h0);
    if (stat) begin
      lmax = strm ? STAT_MAX_LEN : STAT_MAX_LEN >> sh;
      cfg_ok = len >= 32'(STAT_MIN_LEN) && len[4:0] == 5'h00 &&
               {1'b0, len} <= lmax && cnt != 32'h0;
    end else if (w16) begin
      lmax = 33'(AVG_MAX_LEN16) >> sh;
      cfg_ok = len >= 32'(AVG_MIN_LEN16) && len[5:0] == 6'h00 &&
               {1'b0, len} <= lmax && len <= 32'(ACC_DEPTH) &&
               cnt >= 32'(AVG_MIN_COUNT) &&
               cnt <= 32'(AVG_MAX_CNT16);
    end else begin
      lmax = 33'(AVG_MAX_LEN32) >> sh;
      cfg_ok = len >= 32'(AVG_MIN_LEN32) && len[4:0] == 5'h00 &&
               {1'b0, len} <= lmax && len <= 32'(ACC_DEPTH) &&
               cnt >= 32'(AVG_MIN_COUNT) &&
               cnt <= 32'(AVG_MAX_CNT32);
    end
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_have_reg, w_have_reg;
  logic        stat_reg, w16_reg, strm_reg;
  logic [31:0] len_reg, count_reg, ndone_reg;
  logic [2:0]  chan_reg;
  logic        cfgerr_reg, done_reg;
  bas_state_t  state_reg;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take  = s_axi_wvalid && s_axi_wready;
  wire logic do_wr   = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic wr_ctrl = do_wr && awaddr_reg == REG_CTRL && wstrb_reg[0];
  wire logic start   = wr_ctrl && wdata_reg[CTRL_START];
  wire logic abort   = wr_ctrl && wdata_reg[CTRL_ABORT];
  wire logic idle    = state_reg == ST_IDLE;
  wire logic cfg_wr  = do_wr && idle && wstrb_reg == 4'hF;
  wire logic ctl_wr  = cfg_wr && awaddr_reg == REG_CTRL;
  // Start must be checked against the mode written with it
  wire logic stat_next = ctl_wr ? wdata_reg[CTRL_STAT] : stat_reg;
  wire logic w16_next  = ctl_wr ? wdata_reg[CTRL_W16] : w16_reg;
  wire logic strm_next = ctl_wr ? wdata_reg[CTRL_STREAM] : strm_reg;
  wire logic wr_map  = awaddr_reg == REG_CTRL || awaddr_reg == REG_LEN ||
                       awaddr_reg == REG_COUNT || awaddr_reg == REG_CHAN;
  wire logic rd_map  = s_axi_araddr <= REG_DONE &&
                       s_axi_araddr[1:0] == 2'h0;
  wire logic [31:0] rd_word =
    (s_axi_araddr == REG_CTRL)   ? {27'h0, strm_reg, 1'b0, w16_reg,
                                    stat_reg, 1'b0} :
    (s_axi_araddr == REG_LEN)    ? len_reg :
    (s_axi_araddr == REG_COUNT)  ? count_reg :
    (s_axi_araddr == REG_CHAN)   ? {29'h0, chan_reg} :
    (s_axi_araddr == REG_STATUS) ? {29'h0, done_reg, cfgerr_reg, !idle} :
    (s_axi_araddr == REG_DONE)   ? ndone_reg : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      if (aw_take) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_take) begin
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_map ? 2'h0 : 2'h2;
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Settings are frozen while a run is under way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg  <= 1'b0;
      w16_reg   <= 1'b0;
      strm_reg  <= 1'b0;
      len_reg   <= LEN_RST;
      count_reg <= COUNT_RST;
      chan_reg  <= CHAN_RST;
    end else if (cfg_wr) begin
      if (awaddr_reg == REG_CTRL) begin
        stat_reg <= wdata_reg[CTRL_STAT];
        w16_reg  <= wdata_reg[CTRL_W16];
        strm_reg <= wdata_reg[CTRL_STREAM];
      end
      if (awaddr_reg == REG_LEN)   len_reg   <= wdata_reg;
      if (awaddr_reg == REG_COUNT) count_reg <= wdata_reg;
      if (awaddr_reg == REG_CHAN)  chan_reg  <= wdata_reg[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  logic signed [31:0] acc_mem [ACC_DEPTH];
  logic [31:0] idx_reg, pass_reg, addr_reg;
  logic [2:0]  word_reg;
  logic        first_reg, fin_reg, armed_reg, wv_reg;

  wire logic        run_smp  = state_reg == ST_RUN && lnk.smp_valid;
  wire logic        last_smp = run_smp && idx_reg == len_reg - 32'h1;
  wire logic [AW-1:0] ai     = idx_reg[AW-1:0];
  wire logic [AW-1:0] ai1    = AW'(idx_reg + 32'h1);
  wire logic [31:0] sext     = {{24{lnk.smp_data[7]}}, lnk.smp_data};
  wire logic [31:0] step     = w16_reg ? 32'h2 : 32'h1;
  wire logic        last_out = idx_reg + step >= len_reg;
  wire logic [39:0] st_sum;
  wire logic [31:0] st_avg, st_pmin, st_pmax;
  wire logic [7:0]  st_min, st_max;
  wire logic        st_done;
  wire logic [63:0] ts_q;
  logic [63:0]      ts_reg;
  assign ts_q = ts_reg;
  wire logic [31:0] dump_word = w16_reg ?
    {acc_mem[ai1][15:0], acc_mem[ai][15:0]} : acc_mem[ai];
  wire logic [31:0] rec_word =
    (word_reg == 3'h0) ? st_avg :
    (word_reg == 3'h1) ? {16'h0000, st_max, st_min} :
    (word_reg == 3'h2) ? st_pmin :
    (word_reg == 3'h3) ? st_pmax :
    (word_reg == 3'h4) ? ts_q[31:0] :
    (word_reg == 3'h5) ? ts_q[63:32] :
    (word_reg == 3'h6) ? st_sum[31:0] : {24'h00_0000, st_sum[39:32]};

  // Sums live only here; the first pass overwrites, so no clear sweep
  always_ff @(posedge aclk) begin
    if (run_smp && !stat_reg) begin
      acc_mem[ai] <= first_reg ? sext : acc_mem[ai] + sext;
    end
  end

  bas_stat u_stat (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (idx_reg == 32'h0),
    .en       (run_smp && stat_reg),
    .smp      (lnk.smp_data),
    .pos      (idx_reg),
    .finish   (fin_reg),
    .len      (len_reg),
    .min_reg  (st_min),
    .max_reg  (st_max),
    .pmin_reg (st_pmin),
    .pmax_reg (st_pmax),
    .sum_reg  (st_sum),
    .avg_reg  (st_avg),
    .done_reg (st_done)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= ST_IDLE;
      idx_reg    <= 32'h0;
      pass_reg   <= 32'h0;
      addr_reg   <= 32'h0;
      word_reg   <= 3'h0;
      first_reg  <= 1'b0;
      fin_reg    <= 1'b0;
      armed_reg  <= 1'b0;
      wv_reg     <= 1'b0;
      ts_reg     <= 64'h0;
      cfgerr_reg <= 1'b0;
      done_reg   <= 1'b0;
      ndone_reg  <= 32'h0;
    end else begin
      fin_reg <= 1'b0;
      if (abort) begin
        state_reg <= ST_IDLE;
        armed_reg <= 1'b0;
        wv_reg    <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: if (start) begin
            if (cfg_ok(stat_next, w16_next, strm_next, chan_reg,
                       len_reg, count_reg)) begin
              cfgerr_reg <= 1'b0;
              done_reg   <= 1'b0;
              ndone_reg  <= 32'h0;
              pass_reg   <= 32'h0;
              addr_reg   <= 32'h0;
              first_reg  <= 1'b1;
              armed_reg  <= 1'b1;
              state_reg  <= ST_ARM;
            end else begin
              cfgerr_reg <= 1'b1;
            end
          end
          ST_ARM: if (lnk.trig) begin
            armed_reg <= 1'b0;
            ts_reg    <= lnk.ts;
            idx_reg   <= 32'h0;
            state_reg <= ST_RUN;
          end
          ST_RUN: if (run_smp) begin
            idx_reg <= idx_reg + 32'h1;
            if (last_smp && stat_reg) begin
              fin_reg   <= 1'b1;
              state_reg <= ST_DIV;
            end else if (last_smp && pass_reg == count_reg - 32'h1) begin
              idx_reg   <= 32'h0;
              wv_reg    <= 1'b1;
              state_reg <= ST_DUMP;
            end else if (last_smp) begin
              pass_reg  <= pass_reg + 32'h1;
              first_reg <= 1'b0;
              armed_reg <= 1'b1;
              state_reg <= ST_ARM;
            end
          end
          ST_DUMP: if (lnk.wr_ack) begin
            addr_reg <= addr_reg + 32'h4;
            idx_reg  <= idx_reg + step;
            if (last_out) begin
              wv_reg    <= 1'b0;
              done_reg  <= 1'b1;
              ndone_reg <= ndone_reg + 32'h1;
              state_reg <= ST_IDLE;
            end
          end
          ST_DIV: if (st_done) begin
            word_reg  <= 3'h0;
            wv_reg    <= 1'b1;
            state_reg <= ST_REC;
          end
          ST_REC: if (lnk.wr_ack) begin
            addr_reg <= addr_reg + 32'h4;
            word_reg <= word_reg + 3'h1;
            if (word_reg == 3'(REC_WORDS - 1)) begin
              wv_reg    <= 1'b0;
              ndone_reg <= ndone_reg + 32'h1;
              pass_reg  <= pass_reg + 32'h1;
              if (pass_reg == count_reg - 32'h1) begin
                done_reg  <= 1'b1;
                state_reg <= ST_IDLE;
              end else begin
                armed_reg <= 1'b1;
                state_reg <= ST_ARM;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  assign lnk.armed    = armed_reg;
  assign lnk.wr_valid = wv_reg;
  assign lnk.wr_addr  = addr_reg;
  assign lnk.wr_data  = (state_reg == ST_REC) ? rec_word : dump_word;
endmodule // bas_engine

/* File: design/bas_acq.sv */
`timescale 1ns/1ps
module bas_acq import bas_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  bas_if.acq               lnk,
  input  wire logic [7:0]  adc_data,
  input  wire logic        adc_valid,
  input  wire logic        trig_in,
  output logic             mem_valid,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_data,
  input  wire logic        mem_ready
);
  // ----------------------------------------------------------------
  // Pin synchronisers; data and trigger share the same two stages
  // ----------------------------------------------------------------
  logic [9:0]  meta_reg, sync_reg;
  logic        trig_d_reg, trig_reg, ack_reg, sv_reg;
  logic [7:0]  sd_reg;
  logic [63:0] ts_reg;
  wire logic   trig_rise = sync_reg[9] && !trig_d_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg   <= 10'h000;
      sync_reg   <= 10'h000;
      trig_d_reg <= 1'b0;
      trig_reg   <= 1'b0;
      sv_reg     <= 1'b0;
      sd_reg     <= 8'h00;
      ts_reg     <= 64'h0;
      mem_valid  <= 1'b0;
      mem_addr   <= 32'h0;
      mem_data   <= 32'h0;
      ack_reg    <= 1'b0;
    end else begin
      meta_reg   <= {trig_in, adc_valid, adc_data};
      sync_reg   <= meta_reg;
      trig_d_reg <= sync_reg[9];
      ts_reg     <= ts_reg + 64'h1;
      // Trigger only counts while the engine is armed
      trig_reg   <= trig_rise && lnk.armed;
      sv_reg     <= sync_reg[8];
      sd_reg     <= sync_reg[7:0];
      ack_reg    <= 1'b0;
      if (mem_valid && mem_ready) begin
        mem_valid <= 1'b0;
        ack_reg   <= 1'b1;
      end else if (lnk.wr_valid && !mem_valid && !ack_reg) begin
        mem_valid <= 1'b1;
        mem_addr  <= lnk.wr_addr;
        mem_data  <= lnk.wr_data;
      end
    end
  end

  assign lnk.trig      = trig_reg;
  assign lnk.ts        = ts_reg;
  assign lnk.smp_valid = sv_reg;
  assign lnk.smp_data  = sd_reg;
  assign lnk.wr_ack    = ack_reg;
endmodule // bas_acq

/* File: verif/bas_checker.sv */
`timescale 1ns/1ps
module bas_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        trig,
  input wire logic [63:0] ts,
  input wire logic        armed,
  input wire logic        wr_valid,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Expected address of the next word
  // ----------------------------------------------------------------
  logic [31:0] nxt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      nxt_reg <= 32'h0;
    else if (wr_valid && wr_ack)
      nxt_reg <= wr_addr + 32'h4;
  end
  sequence s_hold;
    wr_valid && $stable(wr_addr) && $stable(wr_data);
  endsequence
  // Memory needs a register stage and a ready before it can ack
  sequence s_two_quiet;
    !wr_ack ##1 !wr_ack;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_DROP: assert property (trig && armed |=> !armed)
    else $error("armed stayed high after a trigger");
  AST_GATE: assert property (trig |-> armed)
    else $error("trigger passed while not armed");
  AST_TRIG: assert property (trig |=> !trig)
    else $error("trigger longer than one cycle");
  AST_HOLD: assert property (wr_valid && !wr_ack |=> s_hold)
    else $error("write word changed before ack");
  AST_ACKV: assert property (wr_ack |-> wr_valid)
    else $error("ack without a pending word");
  AST_WAIT: assert property ($rose(wr_valid) |-> s_two_quiet)
    else $error("ack came too early");
  AST_PULSE: assert property (wr_ack |=> !wr_ack)
    else $error("ack longer than one cycle");
  AST_STEP: assert property (wr_valid && wr_ack |->
    wr_addr == nxt_reg || wr_addr == 32'h0)
    else $error("write address did not step by four");
  AST_TS: assert property ($past(aresetn) |-> ts == $past(ts) + 64'h1)
    else $error("timestamp counter did not advance");
endmodule // bas_checker

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import bas_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_addr, mem_data;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, mem_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  adc_data = 8'h00;
  logic        adc_valid = 1'b1, trig_in = 1'b0, mem_ready = 1'b0;
  logic [31:0] q[$];
  int          cyc = 0, fails = 0, n_tests = 0;
  bas_if lnk();
  bas_engine #(.ACC_DEPTH(256), .NEXT_AVG_CYC(256)) u_bas_engine (
    .aclk(aclk), .aresetn(aresetn), .lnk(lnk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  bas_acq u_bas_acq (.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
    .adc_data(adc_data), .adc_valid(adc_valid), .trig_in(trig_in),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
    .mem_ready(mem_ready));
  bas_checker u_bas_checker (.aclk(aclk), .aresetn(aresetn),
    .trig(lnk.trig), .ts(lnk.ts), .armed(lnk.armed),
    .wr_valid(lnk.wr_valid), .wr_addr(lnk.wr_addr),
    .wr_data(lnk.wr_data), .wr_ack(lnk.wr_ack));
  always #2 aclk = ~aclk;
  // ----------------------------------------------------------------
  // Trigger source, stalling memory, capture and timeout
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    trig_in <= cyc[8];
    mem_ready <= cyc[1];
    adc_valid <= cyc[2:0] != 3'h7;
    if (mem_valid === 1'b1 && mem_ready === 1'b1)
      q.push_back(mem_data);
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rst();
    logic [31:0] d;
    logic [1:0]  r;
    rd(REG_LEN, d, r);
    chk(d, LEN_RST);
    rd(REG_COUNT, d, r);
    chk(d, COUNT_RST);
    rd(REG_CHAN, d, r);
    chk(d, {29'h0, CHAN_RST});
    rd(8'h20, d, r);
    chk({30'h0, r}, 32'h2);
    $display("reset test end");
  endtask
  task automatic bad(input logic [31:0] l, input logic [31:0] c,
                     input logic [31:0] k);
    logic [31:0] d;
    logic [1:0]  r;
    wr(REG_LEN, l);
    wr(REG_COUNT, c);
    wr(REG_CTRL, k);
    rd(REG_STATUS, d, r);
    chk({30'h0, d[STS_CFGERR], d[STS_BUSY]}, 32'h2);
    $display("config test end");
  endtask
  // Sums of equal samples show both the signed add and the clear
  task automatic avg(input logic [31:0] l, input logic [31:0] k,
                     input logic [31:0] e, input int n);
    q.delete();
    wr(REG_LEN, l);
    wr(REG_COUNT, 32'h2);
    wr(REG_CHAN, 32'h1);
    wr(REG_CTRL, k);
    while (q.size() < n) @(posedge aclk);
    for (int i = 0; i < n; i++) chk(q[i], e);
    $display("average test end");
  endtask
  task automatic st();
    logic [31:0] d;
    logic [1:0]  r;
    q.delete();
    wr(REG_LEN, 32'h40);
    wr(REG_COUNT, 32'h1);
    wr(REG_CTRL, 32'h3);
    while (q.size() < REC_WORDS) @(posedge aclk);
    repeat (100) @(posedge aclk);
    chk(32'(q.size()), 32'h8);
    chk(q[0], 32'h10);
    chk(q[1], 32'h1010);
    chk(q[2], 32'h0);
    chk(q[3], 32'h0);
    chk(q[6], 32'h400);
    chk(q[7], 32'h0);
    chk(q[5], 32'h0);
    rd(REG_STATUS, d, r);
    chk(d, 32'h4);
    $display("statistics test end");
  endtask
  task automatic results();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_rst();
    bad(32'h41, 32'h2, 32'h1);
    bad(32'h40, 32'h1, 32'h1);
    bad(32'h40, 32'h2, 32'h5);
    bad(32'h80, 32'h101, 32'h5);
    bad(32'h10020, 32'h2, 32'h1);
    bad(32'h30, 32'h1, 32'h3);
    adc_data <= 8'hFD;
    avg(32'h40, 32'h1, 32'hFFFF_FFFA, 64);
    adc_data <= 8'h7F;
    avg(32'h80, 32'h5, 32'h00FE_00FE, 64);
    adc_data <= 8'h10;
    st();
    results();
  end
endmodule // tb
